// *** core/icm_regs.svh ***
// Purpose: offsets, fields, resets and timing counts of one bus channel
// Assumes: included by its bare name
// Notes:   channel c sits at the channel-0 offset plus c times the stride
`ifndef ICM_REGS_SVH
`define ICM_REGS_SVH
`define ICM_CH_STRIDE   8'h10
`define ICM_LOW_OFS     8'hCB
`define ICM_HIGH_OFS    8'hCC
`define ICM_MODE_OFS    8'hCD
`define ICM_TMO_OFS     8'hCE
`define ICM_ON_BIT      7
`define ICM_BR_BIT      5
`define ICM_AR_BIT      4
`define ICM_TE_BIT      7
`define ICM_SPD_RST     2'h2
`define ICM_LOW_RST     8'h5E
`define ICM_HIGH_RST    8'h3F
`define ICM_TMO_RST     8'h00
`define ICM_LOW_MIN_SM  8'h76
`define ICM_LOW_MIN_FM  8'h3B
`define ICM_LOW_MIN_FP  8'h5E
`define ICM_HIGH_MIN_SM 8'h4F
`define ICM_HIGH_MIN_FM 8'h27
`define ICM_HIGH_MIN_FP 8'h3F
`define ICM_SCALE_SM    4'h8
`define ICM_SCALE_FM    4'h4
`define ICM_SCALE_FP    4'h1
`define ICM_REC_PULSES  4'h9
`define ICM_TO_UNIT_US  200
`define ICM_SYS_NS      10
`define ICM_TO_UNIT_CYC ((`ICM_TO_UNIT_US * 1000) / `ICM_SYS_NS)
`endif

// *** core/icm_pkg.sv ***
// Purpose: types of the bus channel
// Assumes: nothing
// Notes:   constants live in icm_regs.svh
package icm_pkg;
    typedef enum logic [1:0] {
        ICM_SM  = 2'b00,
        ICM_FM  = 2'b01,
        ICM_FP  = 2'b10,
        ICM_RSV = 2'b11
    } icm_speed_type;
    typedef enum logic [1:0] {
        REC_IDLE = 2'b00,
        REC_LOW  = 2'b01,
        REC_HIGH = 2'b10
    } icm_rec_type;
endpackage : icm_pkg

// *** core/icm_channel.sv ***
// Purpose: mode, recovery, speed class and low watchdog of one channel
// Assumes: bus strobes on sys_clk; pins sampled on link_clk
// Notes:   the device places three copies, CH_INDEX 0..2
// How it works
// - each channel answers at its own address
// - channel off: both lines released
// - channel off: go bit cannot be set
// - channel on after reset
// - recover request sends nine clock pulses
// - recover request self-clears after the pulses
// - auto recover on data stuck low
// - no auto: abort, flag, interrupt low
// - speed 00 standard, 01 fast, 11 reserved
// - speed resets to fast-plus
// - speed class sets the bus timings
// - counts below class minimum load minimum
// - eight-bit read/write low watch setting
// - watch counter reloads at clock falls
// - counts scaled by 8, 4 or 1
// - top setting bit enables the watch
// - watch period is (count+1) times 200 us
// - expiry: flag, interrupt, release lines
`timescale 1ns/1ps
`include "icm_regs.svh"
module icm_channel
    import icm_pkg::*;
#(
    parameter logic [1:0] CH_INDEX    = 2'h0,
    parameter int         TO_UNIT_CYC = `ICM_TO_UNIT_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        link_clk,
    input  wire logic [7:0]  bus_addr,
    input  wire logic [7:0]  bus_wdata,
    input  wire logic        bus_wr,
    output logic      [7:0]  bus_rdata_q,
    input  wire logic        go_set,
    input  wire logic        go_done,
    input  wire logic        eng_scl_low,
    input  wire logic        eng_sda_low,
    input  wire logic        status_clear,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             scl_o_q,
    output logic             scl_oe_q,
    output logic             sda_o_q,
    output logic             sda_oe_q,
    output logic             go_bit_q,
    output logic             data_line_stuck_error_q,
    output logic             clock_line_stuck_q,
    output logic             xfer_abort_q,
    output logic             int_n_q,
    output logic      [10:0] clk_low_cycles_q,
    output logic      [10:0] clk_high_cycles_q
);
    localparam int PW = $clog2(TO_UNIT_CYC + 1);

    function automatic logic [7:0] chan_addr(input logic [7:0] ofs);
        chan_addr = ofs + 8'(CH_INDEX * `ICM_CH_STRIDE);
    endfunction : chan_addr

    function automatic logic [10:0] scaled(input logic [7:0] raw,
                                           input logic [7:0] lo,
                                           input logic [3:0] sc);
        logic [7:0] eff;
        eff    = (raw < lo) ? lo : raw;
        scaled = {3'h0, eff} * {7'h0, sc};
    endfunction : scaled

    // link side: bus pins, sampled on the link clock
    logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, fall_t_q;
    logic fall_t_d;
    always_comb begin
        fall_t_d = fall_t_q ^ (scl_p_q & ~scl_s_q);
    end
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            scl_m_q  <= 1'b1;
            scl_s_q  <= 1'b1;
            scl_p_q  <= 1'b1;
            sda_m_q  <= 1'b1;
            sda_s_q  <= 1'b1;
            fall_t_q <= 1'b0;
        end else begin
            scl_m_q  <= scl_i;
            scl_s_q  <= scl_m_q;
            scl_p_q  <= scl_s_q;
            sda_m_q  <= sda_i;
            sda_s_q  <= sda_m_q;
            fall_t_q <= fall_t_d;
        end
    end

    // crossing into sys_clk: levels by two flops, the fall event by toggle
    logic scl_y1_q, scl_y2_q, sda_y1_q, sda_y2_q, ft_y1_q, ft_y2_q, ft_y3_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            scl_y1_q <= 1'b1;
            scl_y2_q <= 1'b1;
            sda_y1_q <= 1'b1;
            sda_y2_q <= 1'b1;
            ft_y1_q  <= 1'b0;
            ft_y2_q  <= 1'b0;
            ft_y3_q  <= 1'b0;
        end else begin
            scl_y1_q <= scl_s_q;
            scl_y2_q <= scl_y1_q;
            sda_y1_q <= sda_s_q;
            sda_y2_q <= sda_y1_q;
            ft_y1_q  <= fall_t_q;
            ft_y2_q  <= ft_y1_q;
            ft_y3_q  <= ft_y2_q;
        end
    end
    logic scl_fall;
    assign scl_fall = ft_y2_q ^ ft_y3_q;

    // registers and flags
    icm_speed_type spd_q, spd_d;
    icm_rec_type   rs_q, rs_d;
    logic       on_q, on_d, ar_q, ar_d, br_q, br_d, go_d;
    logic       dae_q, dae_d, cle_q, cle_d, ab_d;
    logic [7:0] low_q, low_d, high_q, high_d, tmo_q, tmo_d, rd_d;
    logic       w_low, w_high, w_mode, w_tmo, stuck, expire, rec_done;
    logic [7:0] mode_rd;

    assign w_low   = bus_wr && (bus_addr == chan_addr(`ICM_LOW_OFS));
    assign w_high  = bus_wr && (bus_addr == chan_addr(`ICM_HIGH_OFS));
    assign w_mode  = bus_wr && (bus_addr == chan_addr(`ICM_MODE_OFS));
    assign w_tmo   = bus_wr && (bus_addr == chan_addr(`ICM_TMO_OFS));
    assign mode_rd = {on_q, 1'b0, br_q, ar_q, 2'b00, spd_q};
    // stuck data: a start is pending, clock high, nobody pulls data yet low
    assign stuck   = on_q && go_bit_q && (rs_q == REC_IDLE) && !br_q
                     && scl_y2_q && !sda_y2_q && !eng_sda_low;

    always_comb begin
        on_d   = on_q;
        ar_d   = ar_q;
        spd_d  = spd_q;
        br_d   = br_q;
        low_d  = w_low ? bus_wdata : low_q;
        high_d = w_high ? bus_wdata : high_q;
        tmo_d  = w_tmo ? bus_wdata : tmo_q;
        go_d   = go_bit_q;
        dae_d  = dae_q;
        cle_d  = cle_q;
        ab_d   = 1'b0;
        if (rec_done)
            br_d = 1'b0;
        if (w_mode) begin
            on_d = bus_wdata[`ICM_ON_BIT];
            ar_d = bus_wdata[`ICM_AR_BIT];
            if (bus_wdata[`ICM_BR_BIT])
                br_d = 1'b1;
            if (bus_wdata[1:0] != ICM_RSV)
                spd_d = icm_speed_type'(bus_wdata[1:0]);
        end
        if (go_done)
            go_d = 1'b0;
        if (go_set && on_q && !br_q)
            go_d = 1'b1;
        if (status_clear) begin
            dae_d = 1'b0;
            cle_d = 1'b0;
        end
        if (stuck && ar_q)
            br_d = 1'b1;
        if (stuck && !ar_q) begin
            dae_d = 1'b1;
            go_d  = 1'b0;
            ab_d  = 1'b1;
        end
        if (expire) begin
            cle_d = 1'b1;
            ab_d  = 1'b1;
        end
        // reads of unmapped addresses return zero
        if (bus_addr == chan_addr(`ICM_LOW_OFS))
            rd_d = low_q;
        else if (bus_addr == chan_addr(`ICM_HIGH_OFS))
            rd_d = high_q;
        else if (bus_addr == chan_addr(`ICM_MODE_OFS))
            rd_d = mode_rd;
        else if (bus_addr == chan_addr(`ICM_TMO_OFS))
            rd_d = tmo_q;
        else
            rd_d = 8'h00;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            on_q        <= 1'b1;
            ar_q        <= 1'b1;
            spd_q       <= icm_speed_type'(`ICM_SPD_RST);
            br_q        <= 1'b0;
            low_q       <= `ICM_LOW_RST;
            high_q      <= `ICM_HIGH_RST;
            tmo_q       <= `ICM_TMO_RST;
            go_bit_q    <= 1'b0;
            dae_q       <= 1'b0;
            cle_q       <= 1'b0;
            bus_rdata_q <= 8'h00;
        end else begin
            on_q        <= on_d;
            ar_q        <= ar_d;
            spd_q       <= spd_d;
            br_q        <= br_d;
            low_q       <= low_d;
            high_q      <= high_d;
            tmo_q       <= tmo_d;
            go_bit_q    <= go_d;
            dae_q       <= dae_d;
            cle_q       <= cle_d;
            bus_rdata_q <= rd_d;
        end
    end

    // speed class: clamp to class minimum, then scale
    logic [7:0]  lo_min, hi_min;
    logic [3:0]  sc;
    logic [10:0] lc_d, hc_d;
    always_comb begin
        case (spd_q)
            ICM_SM: begin
                lo_min = `ICM_LOW_MIN_SM;
                hi_min = `ICM_HIGH_MIN_SM;
                sc     = `ICM_SCALE_SM;
            end
            ICM_FM: begin
                lo_min = `ICM_LOW_MIN_FM;
                hi_min = `ICM_HIGH_MIN_FM;
                sc     = `ICM_SCALE_FM;
            end
            default: begin
                lo_min = `ICM_LOW_MIN_FP;
                hi_min = `ICM_HIGH_MIN_FP;
                sc     = `ICM_SCALE_FP;
            end
        endcase
        lc_d = scaled(low_q, lo_min, sc);
        hc_d = scaled(high_q, hi_min, sc);
    end

    // recovery: nine clock pulses with the class timing, data released
    logic [3:0]  pc_q, pc_d;
    logic [10:0] tm_q, tm_d;
    assign rec_done = (rs_q == REC_HIGH) && (tm_q == 11'h000)
                      && (pc_q == `ICM_REC_PULSES - 4'h1);
    always_comb begin
        rs_d = rs_q;
        pc_d = pc_q;
        tm_d = (tm_q != 11'h000) ? tm_q - 11'h001 : tm_q;
        case (rs_q)
            REC_IDLE: begin
                if (br_q && on_q) begin
                    rs_d = REC_LOW;
                    pc_d = 4'h0;
                    tm_d = clk_low_cycles_q - 11'h001;
                end
            end
            REC_LOW: begin
                if (tm_q == 11'h000) begin
                    rs_d = REC_HIGH;
                    tm_d = clk_high_cycles_q - 11'h001;
                end
            end
            default: begin
                if (rec_done)
                    rs_d = REC_IDLE;
                else if (tm_q == 11'h000) begin
                    rs_d = REC_LOW;
                    pc_d = pc_q + 4'h1;
                    tm_d = clk_low_cycles_q - 11'h001;
                end
            end
        endcase
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rs_q <= REC_IDLE;
            pc_q <= 4'h0;
            tm_q <= 11'h000;
        end else begin
            rs_q <= rs_d;
            pc_q <= pc_d;
            tm_q <= tm_d;
        end
    end

    // clock-low watch; the unit count is approximate by nature
    logic [PW-1:0] pre_q, pre_d;
    logic [6:0]    un_q, un_d;
    logic          unit_end;
    assign unit_end = (pre_q == PW'(TO_UNIT_CYC - 1));
    assign expire   = on_q && tmo_q[`ICM_TE_BIT] && !scl_fall && !scl_y2_q
                      && unit_end && (un_q == 7'h00);
    always_comb begin
        pre_d = pre_q;
        un_d  = un_q;
        // held in reload while high, so a new low never inherits old progress
        if (!on_q || !tmo_q[`ICM_TE_BIT] || scl_fall || scl_y2_q) begin
            pre_d = '0;
            un_d  = tmo_q[6:0];
        end else begin
            pre_d = unit_end ? '0 : pre_q + PW'(1);
            if (unit_end && un_q != 7'h00)
                un_d = un_q - 7'h01;
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pre_q <= '0;
            un_q  <= 7'h00;
        end else begin
            pre_q <= pre_d;
            un_q  <= un_d;
        end
    end

    // pin drive and outputs; lines only driven low, release wins
    logic scl_oe_d, sda_oe_d;
    always_comb begin
        scl_oe_d = on_q && !cle_q && ((rs_q == REC_LOW)
                   || (rs_q == REC_IDLE && eng_scl_low));
        sda_oe_d = on_q && !cle_q && (rs_q == REC_IDLE) && eng_sda_low;
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            scl_o_q                 <= 1'b0;
            sda_o_q                 <= 1'b0;
            scl_oe_q                <= 1'b0;
            sda_oe_q                <= 1'b0;
            xfer_abort_q            <= 1'b0;
            int_n_q                 <= 1'b1;
            data_line_stuck_error_q <= 1'b0;
            clock_line_stuck_q      <= 1'b0;
            clk_low_cycles_q        <= 11'h000;
            clk_high_cycles_q       <= 11'h000;
        end else begin
            scl_o_q                 <= 1'b0;
            sda_o_q                 <= 1'b0;
            scl_oe_q                <= scl_oe_d;
            sda_oe_q                <= sda_oe_d;
            xfer_abort_q            <= ab_d;
            int_n_q                 <= !(dae_d || cle_d);
            data_line_stuck_error_q <= dae_d;
            clock_line_stuck_q      <= cle_d;
            clk_low_cycles_q        <= lc_d;
            clk_high_cycles_q       <= hc_d;
        end
    end

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    logic [3:0] lows_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            lows_q <= 4'h0;
        else if (rs_q == REC_IDLE)
            lows_q <= 4'h0;
        else if (rs_q == REC_LOW && $past(rs_q) != REC_LOW)
            lows_q <= lows_q + 4'h1;
    end
    sequence rec_start_s;
        rs_q == REC_IDLE && br_q && on_q ##1 rs_q == REC_LOW;
    endsequence
    sequence rec_end_s;
        rec_done ##1 rs_q == REC_IDLE;
    endsequence
    off_release_a: assert property (!on_q |=> !scl_oe_q && !sda_oe_q)
        else $error("lines driven while channel off");
    go_refuse_a: assert property ($rose(go_bit_q) |-> $past(on_q) && !$past(br_q))
        else $error("go bit set while off or recovering");
    rec_begin_a: assert property (rec_start_s |-> ##1 scl_oe_q)
        else $error("recovery did not pull clock low");
    rec_nine_a: assert property (rec_end_s |-> $past(lows_q, 2) == 4'h9)
        else $error("recovery pulse count not nine");
    self_clear_a: assert property (rec_done && !w_mode && !stuck |=> !br_q)
        else $error("recover request not cleared");
    auto_rec_a: assert property (stuck && ar_q |=> br_q && !dae_q)
        else $error("auto recovery not started");
    dae_abort_a: assert property (stuck && !ar_q |=> dae_q && xfer_abort_q && !int_n_q)
        else $error("stuck data not flagged");
    rsv_speed_a: assert property (w_mode && bus_wdata[1:0] == 2'b11 |=> spd_q != ICM_RSV)
        else $error("reserved speed retained");
    sm_clamp_a: assert property (spd_q == ICM_SM |=> clk_low_cycles_q >= 11'h3B0)
        else $error("standard low count under minimum");
    reload_a: assert property (scl_fall && on_q && tmo_q[7] |=> un_q == $past(tmo_q[6:0]))
        else $error("watch counter not reloaded");
    cle_release_a: assert property (expire |=> cle_q ##1 !scl_oe_q && !sda_oe_q)
        else $error("lines not released after expiry");
endmodule : icm_channel

// *** dv/icm_bus_model.sv ***
// Purpose: open-drain line pair with pull-ups and one target on it
// Assumes: an enable high pulls its line low
// Notes:   a stuck target lets go of data after three clock falls
`timescale 1ns/1ps
module icm_bus_model (
    input  wire logic scl_oe,
    input  wire logic sda_oe,
    input  wire logic hold_scl,
    input  wire logic hold_sda,
    input  wire logic clr,
    output logic      scl,
    output logic      sda,
    output int        pulses
);
    // released lines float up to the pull-up level, never keep a driven value
    assign scl = !(scl_oe || hold_scl);
    assign sda = !(sda_oe || (hold_sda && pulses < 3));
    always @(negedge scl or posedge clr) begin
        if (clr) begin
            pulses <= 0;
        end else begin
            pulses <= pulses + 1;
        end
    end
endmodule : icm_bus_model

// *** dv/icm_channel_tb_top.sv ***
// Purpose: self-checking bench for one bus channel and its line model
// Assumes: channel index 1, watch unit cut to 20 cycles
// Notes:   expected counts come from the class minimum and scale tables
`timescale 1ns/1ps
`include "icm_regs.svh"
module icm_channel_tb_top;
    localparam int         UNIT   = 20; // short unit keeps watch runs brief
    localparam logic [7:0] A_LO   = `ICM_LOW_OFS + `ICM_CH_STRIDE;
    localparam logic [7:0] A_HI   = `ICM_HIGH_OFS + `ICM_CH_STRIDE;
    localparam logic [7:0] A_MODE = `ICM_MODE_OFS + `ICM_CH_STRIDE;
    localparam logic [7:0] A_WTO  = `ICM_TMO_OFS + `ICM_CH_STRIDE;
    logic        sys_clk, link_clk, rstn, bus_wr, go_set, go_done, eng_scl_low, status_clear;
    logic        scl_i, sda_i, scl_o_q, scl_oe_q, sda_o_q, sda_oe_q, go_bit_q, int_n_q;
    logic        data_line_stuck_error_q, clock_line_stuck_q, xfer_abort_q, eng_sda_low;
    logic        hold_scl, hold_sda, clr;
    logic [7:0]  bus_addr, bus_wdata, bus_rdata_q, d, m, lo, hi;
    logic [1:0]  cur;
    logic [10:0] clk_low_cycles_q, clk_high_cycles_q;
    logic [7:0]  lo_min [0:2] = '{`ICM_LOW_MIN_SM, `ICM_LOW_MIN_FM, `ICM_LOW_MIN_FP};
    logic [7:0]  hi_min [0:2] = '{`ICM_HIGH_MIN_SM, `ICM_HIGH_MIN_FM, `ICM_HIGH_MIN_FP};
    logic [3:0]  scale  [0:2] = '{`ICM_SCALE_SM, `ICM_SCALE_FM, `ICM_SCALE_FP};
    logic [1:0]  spd    [0:3] = '{2'h0, 2'h1, 2'h3, 2'h2};
    int          pulses, n, mismatches, compares;

    icm_channel #(.CH_INDEX(2'h1), .TO_UNIT_CYC(UNIT)) icm_channel_i (
        .sys_clk(sys_clk), .rstn(rstn), .link_clk(link_clk), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rdata_q(bus_rdata_q),
        .go_set(go_set), .go_done(go_done), .eng_scl_low(eng_scl_low),
        .eng_sda_low(eng_sda_low), .status_clear(status_clear), .scl_i(scl_i), .sda_i(sda_i),
        .scl_o_q(scl_o_q), .scl_oe_q(scl_oe_q), .sda_o_q(sda_o_q), .sda_oe_q(sda_oe_q),
        .go_bit_q(go_bit_q), .data_line_stuck_error_q(data_line_stuck_error_q),
        .clock_line_stuck_q(clock_line_stuck_q), .xfer_abort_q(xfer_abort_q),
        .int_n_q(int_n_q), .clk_low_cycles_q(clk_low_cycles_q),
        .clk_high_cycles_q(clk_high_cycles_q));
    icm_bus_model icm_bus_model_i (.scl_oe(scl_oe_q), .sda_oe(sda_oe_q), .hold_scl(hold_scl),
        .hold_sda(hold_sda), .clr(clr), .scl(scl_i), .sda(sda_i), .pulses(pulses));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        link_clk = 1'b0;
        #3.7;
        forever #40 link_clk = ~link_clk;
    end

    function automatic logic [10:0] cyc(logic [1:0] s, logic [7:0] v, logic h);
        logic [7:0] mn;
        mn = h ? hi_min[s] : lo_min[s];
        return {3'h0, (v < mn) ? mn : v} * {7'h0, scale[s]};
    endfunction : cyc

    task automatic tick(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        bus_addr = a;
        bus_wdata = v;
        bus_wr = 1'b1;
        tick(1);
        bus_wr = 1'b0;
        tick(1);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        bus_addr = a;
        tick(2);
        v = bus_rdata_q;
    endtask : rd
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask : pulse
    task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic chkb(input logic got, input logic exp, input string what);
        chk({10'h0, got}, {10'h0, exp}, what);
    endtask : chkb
    task automatic hang(input string what);
        mismatches++;
        $display("unexpected at %0t: %s never came", $time, what);
        conclude();
    endtask : hang
    task automatic wait_br(output logic [7:0] v);
        for (int i = 0; i < 4000; i++) begin
            rd(A_MODE, v);
            if (v[5] === 1'b0) begin
                return;
            end
        end
        hang("recovery end");
    endtask : wait_br
    task automatic wait_hi(input logic k);
        for (n = 0; n < 200; n++) begin
            if ((k ? clock_line_stuck_q : xfer_abort_q) === 1'b1) begin
                return;
            end
            tick(1);
        end
        hang("stuck flag");
    endtask : wait_hi
    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    initial begin
        {bus_wr, go_set, go_done, eng_scl_low, status_clear, hold_scl, hold_sda, clr} = '0;
        {bus_addr, bus_wdata} = '0;
        eng_sda_low = 1'b0;
        cur = 2'h2;
        rstn = 1'b0;
        void'($urandom(32'h4b95));
        repeat (16) @(posedge sys_clk);
        #1 rstn = 1'b1;
        rd(A_MODE, d);
        chk(11'(d), 11'h92, "mode reset");
        chk(clk_low_cycles_q, cyc(2'h2, `ICM_LOW_RST, 1'b0), "low reset");
        chk(clk_high_cycles_q, cyc(2'h2, `ICM_HIGH_RST, 1'b1), "high reset");
        rd(8'hCD, d);
        chk(11'(d), 11'h0, "other channel");
        wr(8'hCD, 8'h00);
        rd(A_MODE, d);
        chk(11'(d), 11'h92, "own mode kept");
        m = 8'($urandom);
        wr(A_WTO, m);
        rd(A_WTO, d);
        chk(11'(d), 11'(m), "watch setting");
        wr(A_WTO, 8'h00);
        done("map");
        foreach (spd[k]) begin
            m = 8'($urandom);
            m[7] = 1'b1;
            m[5] = 1'b0;
            m[1:0] = spd[k];
            lo = (k == 0) ? 8'h01 : 8'($urandom);
            hi = 8'($urandom);
            wr(A_MODE, m);
            if (spd[k] != 2'h3) begin
                cur = spd[k];
            end
            wr(A_LO, lo);
            wr(A_HI, hi);
            rd(A_MODE, d);
            chk(11'(d), 11'({m[7], 1'b0, m[5:4], 2'h0, cur}), "mode");
            chk(clk_low_cycles_q, cyc(cur, lo, 1'b0), "low cycles");
            chk(clk_high_cycles_q, cyc(cur, hi, 1'b1), "high cycles");
        end
        done("speed");
        wr(A_MODE, 8'h12);
        pulse(go_set);
        chkb(go_bit_q, 1'b0, "go while off");
        {eng_scl_low, eng_sda_low} = 2'b11;
        tick(3);
        chk(11'({scl_oe_q, sda_oe_q}), 11'h0, "lines while off");
        {eng_scl_low, eng_sda_low} = 2'b00;
        wr(A_LO, 8'hA5);
        rd(A_LO, d);
        chk(11'(d), 11'hA5, "low while off");
        wr(A_MODE, 8'h92);
        pulse(go_set);
        chkb(go_bit_q, 1'b1, "go set");
        pulse(go_done);
        chkb(go_bit_q, 1'b0, "go done");
        {eng_scl_low, eng_sda_low} = 2'b11;
        tick(3);
        chk(11'({scl_oe_q, sda_oe_q, scl_o_q, sda_o_q}), 11'hC, "lines while on");
        {eng_scl_low, eng_sda_low} = 2'b00;
        done("enable");
        pulse(clr);
        wr(A_MODE, 8'hB2);
        pulse(go_set);
        chkb(go_bit_q, 1'b0, "go in recovery");
        wait_br(d);
        chk(11'(d), 11'h92, "mode after recovery");
        chk(11'(pulses), 11'd9, "recovery clocks");
        pulse(clr);
        pulse(go_set);
        hold_sda = 1'b1;
        tick(40);
        rd(A_MODE, d);
        chkb(d[5], 1'b1, "auto recovery start");
        wait_br(d);
        chk(11'(pulses), 11'd9, "auto recovery clocks");
        hold_sda = 1'b0;
        pulse(go_done);
        done("recovery");
        wr(A_MODE, 8'h82);
        pulse(clr);
        pulse(go_set);
        hold_sda = 1'b1;
        wait_hi(1'b0);
        chkb(data_line_stuck_error_q, 1'b1, "data flag");
        chkb(int_n_q, 1'b0, "data interrupt");
        chkb(go_bit_q, 1'b0, "go after abort");
        hold_sda = 1'b0;
        pulse(status_clear);
        tick(1);
        chkb(int_n_q, 1'b1, "interrupt cleared");
        done("no auto");
        wr(A_WTO, 8'h82);
        hold_scl = 1'b1;
        tick(50);
        hold_scl = 1'b0;
        tick(20);
        chkb(clock_line_stuck_q, 1'b0, "early expiry");
        hold_scl = 1'b1;
        eng_scl_low = 1'b1;
        wait_hi(1'b1);
        chkb(n >= 3 * UNIT && n <= 3 * UNIT + 40, 1'b1, "expiry time");
        tick(2);
        chk(11'({int_n_q, scl_oe_q, sda_oe_q}), 11'h0, "release on expiry");
        {hold_scl, eng_scl_low} = 2'b00;
        pulse(status_clear);
        tick(1);
        chkb(clock_line_stuck_q, 1'b0, "clock flag cleared");
        wr(A_WTO, 8'h02);
        hold_scl = 1'b1;
        tick(150);
        chkb(clock_line_stuck_q, 1'b0, "watch off");
        hold_scl = 1'b0;
        done("watch");
        conclude();
    end
endmodule : icm_channel_tb_top
